// ### shared/qvc_if.sv
`timescale 1ns/1ps
interface qvc_if;
	logic supply_on;
	logic fb_up;
	logic fb_down;
	logic fb_rapid;
	logic zc;
	logic cs_trip;
	logic line_high;
	modport src  (output supply_on, fb_up, fb_down, fb_rapid, zc, cs_trip, line_high);
	modport sink (input supply_on, fb_up, fb_down, fb_rapid, zc, cs_trip, line_high);
endinterface

// ### shared/qvc_params.svh
`ifndef QVC_PARAMS_SVH
`define QVC_PARAMS_SVH
// Notes on behaviour
// [RQ1] Supply on: stop charging, start soft-start.
// [RQ2] Soft-start lasts 12 ms in four steps.
// [RQ3] Sense limit steps 0.32 V up to 1 V.
// [RQ4] Valley logic switches on, sense comparator off.
// [RQ5] Valley counter holds switch-on crossing index.
// [RQ6] Judge feedback thresholds once every 48 ms.
// [RQ7] Always below low threshold: count up, max 7.
// [RQ8] Between low and high thresholds: hold value.
// [RQ9] Above high, below rapid: count down, min 1.
// [RQ10] Above rapid threshold: force counter to 1 at once.
// [RQ11] Counter stays 1 to 7, excess steps ignored.
// [RQ12] Counter starts at 1 after power-up.
// [RQ13] Count thresholds chosen by line voltage level.
// [RQ14] Crossing tally 0 to 7, counts falling crossings.
// [RQ15] Tally clears whenever gate drive goes high.
// [RQ16] After ringing suppression, on when tally reaches counter.
// [RQ17] Off for maximum interval: switch on regardless.
// [RQ18] Threshold latches per period, cleared each period.
// [RQ19] Soft-start steps timed by counting clock cycles.

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define QVC_CLK_MHZ        100
`define QVC_PERIOD_MS      48
`define QVC_PERIOD_CYCLES  (`QVC_PERIOD_MS * 1000 * `QVC_CLK_MHZ)
`define QVC_SS_TOTAL_MS    12
`define QVC_SS_STEPS       4
`define QVC_SS_STEP_CYCLES ((`QVC_SS_TOTAL_MS * 1000 * `QVC_CLK_MHZ) / `QVC_SS_STEPS)
`define QVC_MAX_OFF_US     50
`define QVC_MAX_OFF_CYCLES (`QVC_MAX_OFF_US * `QVC_CLK_MHZ)
`define QVC_RING_NS        2000
`define QVC_RING_CYCLES    ((`QVC_RING_NS * `QVC_CLK_MHZ + 999) / 1000)

// ----------------------------------------------------------------
// Counter limits and levels
// ----------------------------------------------------------------
`define QVC_VALLEY_MIN 3'h1
`define QVC_VALLEY_MAX 3'h7
`define QVC_TALLY_MAX  3'h7
`define QVC_LIM_STEP0  10'h140
`define QVC_LIM_STEP1  10'h223
`define QVC_LIM_STEP2  10'h305
`define QVC_LIM_STEP3  10'h3E8
`define QVC_IN_W       7
`endif

// ### shared/qvc_pkg.sv
package qvc_pkg;
	typedef enum logic [1:0] {QVC_IDLE, QVC_SOFT, QVC_RUN} qvc_state_e;

	typedef struct packed {
		qvc_state_e  state;
		logic [31:0] per_cnt;
		logic [31:0] ss_cnt;
		logic [1:0]  ss_step;
		logic [9:0]  limit;
		logic        lat_up;
		logic        lat_down;
		logic        lat_rapid;
		logic [2:0]  valley;
		logic [2:0]  tally;
		logic        gate;
		logic [31:0] off_cnt;
		logic        zc_prev;
		logic        charge;
		logic        line_sel;
	} qvc_core_s;
endpackage

// ### src/qvc_core.sv
`timescale 1ns/1ps
`include "qvc_params.svh"
module qvc_core #(
	parameter int PERIOD_CYCLES  = `QVC_PERIOD_CYCLES,
	parameter int SS_STEP_CYCLES = `QVC_SS_STEP_CYCLES,
	parameter int MAX_OFF_CYCLES = `QVC_MAX_OFF_CYCLES,
	parameter int RING_CYCLES    = `QVC_RING_CYCLES
) (
	input  wire logic       CLK_SYS,
	input  wire logic       RSTN,
	input  wire logic       SUPPLY_ON,
	input  wire logic       FB_ABOVE_UP,
	input  wire logic       FB_ABOVE_DOWN,
	input  wire logic       FB_ABOVE_RAPID,
	input  wire logic       VALLEY_SENSE,
	input  wire logic       CS_TRIP,
	input  wire logic       LINE_HIGH,
	output logic            STARTUP_CHARGE_EN,
	output logic            GATE_DRIVE,
	output logic [2:0]      VALLEY_INDEX,
	output logic [2:0]      CROSSING_TALLY,
	output logic [9:0]      CS_LIMIT_MV,
	output logic            FB_THRESH_SEL
);
	qvc_if in_if ();

	qvc_sync #(
		.W(`QVC_IN_W)
	) u_sync (
		.clk  (CLK_SYS),
		.rst_n(RSTN),
		.raw  ({LINE_HIGH, CS_TRIP, VALLEY_SENSE, FB_ABOVE_RAPID, FB_ABOVE_DOWN, FB_ABOVE_UP, SUPPLY_ON}),
		.bus  (in_if.src)
	);

	qvc_pkg::qvc_core_s r_reg;
	qvc_pkg::qvc_core_s r_next;

	function automatic logic [9:0] step_limit(input logic [1:0] step);
		case (step)
			2'h0:    step_limit = `QVC_LIM_STEP0;
			2'h1:    step_limit = `QVC_LIM_STEP1;
			2'h2:    step_limit = `QVC_LIM_STEP2;
			default: step_limit = `QVC_LIM_STEP3;
		endcase
	endfunction

	// ----------------------------------------------------------------
	// Sequencing, valley counter and gate timing.
	// ----------------------------------------------------------------
	logic active;
	logic period_end;
	logic l_up;
	logic l_down;
	logic l_rapid;
	logic zc_fall;
	logic ring_done;
	logic max_off;

	assign active     = r_reg.state != qvc_pkg::QVC_IDLE;
	assign period_end = r_reg.per_cnt == 32'(PERIOD_CYCLES - 1);
	assign l_up       = r_reg.lat_up | in_if.fb_up;
	assign l_down     = r_reg.lat_down | in_if.fb_down;
	assign l_rapid    = r_reg.lat_rapid | in_if.fb_rapid;
	assign zc_fall    = in_if.zc & ~r_reg.zc_prev;
	assign ring_done  = r_reg.off_cnt >= 32'(RING_CYCLES);
	assign max_off    = r_reg.off_cnt >= 32'(MAX_OFF_CYCLES - 1);

	always_comb begin
		r_next          = r_reg;
		r_next.zc_prev  = in_if.zc;
		r_next.line_sel = in_if.line_high; // [RQ13]
		case (r_reg.state)
			qvc_pkg::QVC_IDLE: begin
				r_next.charge = 1'b1;
				if (in_if.supply_on) begin
					r_next.state   = qvc_pkg::QVC_SOFT; // [RQ1]
					r_next.charge  = 1'b0; // [RQ1]
					r_next.valley  = `QVC_VALLEY_MIN; // [RQ12]
					r_next.ss_step = 2'h0;
					r_next.ss_cnt  = '0;
					r_next.limit   = step_limit(2'h0); // [RQ3]
					r_next.per_cnt = '0;
					r_next.off_cnt = 32'(MAX_OFF_CYCLES - 1);
				end
			end
			qvc_pkg::QVC_SOFT: begin
				if (r_reg.ss_cnt == 32'(SS_STEP_CYCLES - 1)) begin // [RQ19]
					r_next.ss_cnt = '0;
					if (r_reg.ss_step == 2'(`QVC_SS_STEPS - 1)) begin // [RQ2]
						r_next.state = qvc_pkg::QVC_RUN;
					end else begin
						r_next.ss_step = r_reg.ss_step + 2'h1;
						r_next.limit   = step_limit(r_reg.ss_step + 2'h1); // [RQ3]
					end
				end else begin
					r_next.ss_cnt = r_reg.ss_cnt + 32'h1;
				end
			end
			qvc_pkg::QVC_RUN: begin
				r_next.limit = `QVC_LIM_STEP3;
			end
			default: begin
				r_next.state = qvc_pkg::QVC_IDLE;
			end
		endcase

		if (active) begin
			if (period_end) begin // [RQ6]
				r_next.per_cnt   = '0;
				r_next.lat_up    = 1'b0; // [RQ18]
				r_next.lat_down  = 1'b0;
				r_next.lat_rapid = 1'b0;
				if (l_rapid) begin
					r_next.valley = `QVC_VALLEY_MIN;
				end else if (l_down) begin
					if (r_reg.valley > `QVC_VALLEY_MIN) begin // [RQ9] [RQ11]
						r_next.valley = r_reg.valley - 3'h1;
					end
				end else if (l_up) begin
					r_next.valley = r_reg.valley; // [RQ8]
				end else if (r_reg.valley < `QVC_VALLEY_MAX) begin // [RQ7] [RQ11]
					r_next.valley = r_reg.valley + 3'h1;
				end
			end else begin
				r_next.per_cnt   = r_reg.per_cnt + 32'h1;
				r_next.lat_up    = l_up; // [RQ18]
				r_next.lat_down  = l_down;
				r_next.lat_rapid = l_rapid;
			end
			if (in_if.fb_rapid) begin
				r_next.valley = `QVC_VALLEY_MIN; // [RQ10]
			end

			if (r_reg.gate) begin
				if (in_if.cs_trip) begin // [RQ4]
					r_next.gate    = 1'b0;
					r_next.off_cnt = '0;
				end
			end else begin
				if (!max_off) begin
					r_next.off_cnt = r_reg.off_cnt + 32'h1;
				end
				if (zc_fall && r_reg.tally < `QVC_TALLY_MAX) begin // [RQ14]
					r_next.tally = r_reg.tally + 3'h1;
				end
				if ((ring_done && r_reg.tally >= r_reg.valley) || max_off) begin // [RQ16] [RQ17] [RQ5]
					r_next.gate  = 1'b1;
					r_next.tally = '0; // [RQ15]
				end
			end
		end

		if (!in_if.supply_on) begin
			r_next.state  = qvc_pkg::QVC_IDLE;
			r_next.gate   = 1'b0;
			r_next.charge = 1'b1;
			r_next.tally  = '0;
		end
	end

	always_ff @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN) begin
			r_reg        <= '0;
			r_reg.state  <= qvc_pkg::QVC_IDLE;
			r_reg.valley <= `QVC_VALLEY_MIN;
			r_reg.charge <= 1'b1;
			r_reg.limit  <= `QVC_LIM_STEP0;
		end else begin
			r_reg <= r_next;
		end
	end

	assign STARTUP_CHARGE_EN = r_reg.charge;
	assign GATE_DRIVE        = r_reg.gate;
	assign VALLEY_INDEX      = r_reg.valley;
	assign CROSSING_TALLY    = r_reg.tally;
	assign CS_LIMIT_MV       = r_reg.limit;
	assign FB_THRESH_SEL     = r_reg.line_sel;

	// ----------------------------------------------------------------
	// Checks.
	// ----------------------------------------------------------------
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (!RSTN);

	charge_off_a: assert property (active |-> !STARTUP_CHARGE_EN) // [RQ1]
		else $error("Charging path on while operating.");
	valley_range_a: assert property (VALLEY_INDEX >= 3'h1 && VALLEY_INDEX <= 3'h7) // [RQ11]
		else $error("Valley index out of range.");
	rapid_force_a: assert property (active && in_if.fb_rapid && in_if.supply_on |=> VALLEY_INDEX == 3'h1) // [RQ10]
		else $error("Rapid reset did not force valley to one.");
	up_count_a: assert property (active && in_if.supply_on && period_end && !l_up && !l_down && !l_rapid // [RQ7]
		&& VALLEY_INDEX < 3'h7 |=> VALLEY_INDEX == $past(VALLEY_INDEX) + 3'h1)
		else $error("Valley did not count up.");
	down_count_a: assert property (active && in_if.supply_on && period_end && l_down && !l_rapid // [RQ9]
		&& VALLEY_INDEX > 3'h1 |=> VALLEY_INDEX == $past(VALLEY_INDEX) - 3'h1)
		else $error("Valley did not count down.");
	hold_mid_a: assert property (active && !period_end && !in_if.fb_rapid |=> $stable(VALLEY_INDEX)) // [RQ6]
		else $error("Valley changed outside period end.");
	tally_clear_a: assert property ($rose(GATE_DRIVE) |-> CROSSING_TALLY == 3'h0) // [RQ15]
		else $error("Tally not cleared at gate on.");
	gate_cause_a: assert property ($rose(GATE_DRIVE) |-> $past(max_off) // [RQ16]
		|| ($past(ring_done) && $past(CROSSING_TALLY) >= $past(VALLEY_INDEX)))
		else $error("Gate turned on without cause.");
	max_off_a: assert property (active && !GATE_DRIVE && max_off && in_if.supply_on |=> GATE_DRIVE) // [RQ17]
		else $error("Maximum off interval ignored.");
	cs_off_a: assert property (GATE_DRIVE && in_if.cs_trip |=> !GATE_DRIVE) // [RQ4]
		else $error("Gate stayed on after sense trip.");
	ss_step_a: assert property (r_reg.state == qvc_pkg::QVC_SOFT && r_reg.ss_cnt == 32'(SS_STEP_CYCLES - 1) // [RQ19]
		&& r_reg.ss_step != 2'h3 && in_if.supply_on |=> CS_LIMIT_MV > $past(CS_LIMIT_MV))
		else $error("Soft-start step did not advance.");
	ss_end_a: assert property (r_reg.state == qvc_pkg::QVC_RUN |-> CS_LIMIT_MV == 10'h3E8) // [RQ2]
		else $error("Run limit not at final level.");
endmodule

// ### src/qvc_sync.sv
`timescale 1ns/1ps
`include "qvc_params.svh"
module qvc_sync #(
	parameter int W = `QVC_IN_W
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] raw,
	qvc_if.src                bus
);
	typedef struct packed {
		logic [W-1:0] ff1;
		logic [W-1:0] ff2;
		logic [W-1:0] ff3;
		logic [W-1:0] stable;
	} qvc_sync_s;

	qvc_sync_s s_reg;
	qvc_sync_s s_next;

	// ----------------------------------------------------------------
	// Three stages; a bit changes once stages two and three agree.
	// ----------------------------------------------------------------
	always_comb begin
		s_next     = s_reg;
		s_next.ff1 = raw;
		s_next.ff2 = s_reg.ff1;
		s_next.ff3 = s_reg.ff2;
		for (int i = 0; i < W; i++) begin
			if (s_reg.ff2[i] == s_reg.ff3[i]) begin
				s_next.stable[i] = s_reg.ff3[i];
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign bus.supply_on = s_reg.stable[0];
	assign bus.fb_up     = s_reg.stable[1];
	assign bus.fb_down   = s_reg.stable[2];
	assign bus.fb_rapid  = s_reg.stable[3];
	assign bus.zc        = s_reg.stable[4];
	assign bus.cs_trip   = s_reg.stable[5];
	assign bus.line_high = s_reg.stable[6];
endmodule

// ### verification/qvc_cmp_model.sv
`timescale 1ns/1ps
module qvc_cmp_model (
	input  wire logic clk,
	input  wire logic gate,
	input  wire logic pulse_en,
	output logic      cs_trip,
	output logic      valley_sense
);
	// ----------------------------------------------------------------
	// Comparator behaviour seen across the switch
	// ----------------------------------------------------------------
	logic [3:0] on_cnt;
	logic [3:0] off_cnt;

	// The sense comparator trips a few cycles into each on phase.
	// Ringing gives one crossing every eight cycles while the switch is off.
	always @(posedge clk) begin
		on_cnt <= gate ? on_cnt + 4'h1 : 4'h0;
		cs_trip <= gate && (on_cnt >= 4'h5);
		off_cnt <= (gate || !pulse_en) ? 4'h0 : off_cnt + 4'h1;
		valley_sense <= pulse_en && !gate && (off_cnt[2:0] >= 3'h4);
	end
endmodule

// ### verification/tb_qr_valley_count_control.sv
`timescale 1ns/1ps
module tb_qr_valley_count_control;
	// ----------------------------------------------------------------
	// Signals
	// ----------------------------------------------------------------
	logic       CLK_SYS, RSTN, SUPPLY_ON, FB_ABOVE_UP, FB_ABOVE_DOWN, FB_ABOVE_RAPID;
	logic       VALLEY_SENSE, CS_TRIP, LINE_HIGH, STARTUP_CHARGE_EN, GATE_DRIVE;
	logic       FB_THRESH_SEL, pulse_en, started, g_q;
	logic [2:0] VALLEY_INDEX, CROSSING_TALLY, t_q, v_q;
	logic [9:0] CS_LIMIT_MV;
	int         failures, num_checks, n;
	logic [4:0] rows [18] = '{5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07, 5'h07, 5'h0F, 5'h0F,
		5'h16, 5'h15, 5'h0C, 5'h0C, 5'h19, 5'h11, 5'h11, 5'h01, 5'h02};

	qvc_core #(.PERIOD_CYCLES(200), .SS_STEP_CYCLES(50), .MAX_OFF_CYCLES(100), .RING_CYCLES(10)) DUT (
		.CLK_SYS(CLK_SYS), .RSTN(RSTN), .SUPPLY_ON(SUPPLY_ON), .FB_ABOVE_UP(FB_ABOVE_UP),
		.FB_ABOVE_DOWN(FB_ABOVE_DOWN), .FB_ABOVE_RAPID(FB_ABOVE_RAPID), .VALLEY_SENSE(VALLEY_SENSE),
		.CS_TRIP(CS_TRIP), .LINE_HIGH(LINE_HIGH), .STARTUP_CHARGE_EN(STARTUP_CHARGE_EN),
		.GATE_DRIVE(GATE_DRIVE), .VALLEY_INDEX(VALLEY_INDEX), .CROSSING_TALLY(CROSSING_TALLY),
		.CS_LIMIT_MV(CS_LIMIT_MV), .FB_THRESH_SEL(FB_THRESH_SEL));

	qvc_cmp_model far (.clk(CLK_SYS), .gate(GATE_DRIVE), .pulse_en(pulse_en), .cs_trip(CS_TRIP),
		.valley_sense(VALLEY_SENSE));

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic check(input string name, input logic [9:0] seen, input logic [9:0] exp);
		num_checks++;
		if (seen !== exp) begin
			failures++;
			$display("[FAIL] %s expected %0d seen %0d", name, exp, seen);
		end
	endtask

	task automatic wait_cyc(input int c);
		repeat (c) @(posedge CLK_SYS);
		#1;
	endtask

	task automatic wait_gate(input logic lvl, output int k);
		k = 0;
		while (GATE_DRIVE !== lvl && k < 400) begin
			wait_cyc(1);
			k++;
		end
	endtask

	task automatic idle_vals();
		check("charge", 10'(STARTUP_CHARGE_EN), 10'h001);
		check("gate", 10'(GATE_DRIVE), 10'h000);
		check("tally", 10'(CROSSING_TALLY), 10'h000);
	endtask

	task automatic stop_test();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Clock, watchdog and switch-on monitor
	// ----------------------------------------------------------------
	initial begin
		CLK_SYS = 1'b0;
		forever #5 CLK_SYS = ~CLK_SYS;
	end

	initial begin
		repeat (20000) @(posedge CLK_SYS);
		failures++;
		stop_test();
	end

	always @(negedge CLK_SYS) begin
		if (RSTN && SUPPLY_ON && pulse_en && started && GATE_DRIVE && !g_q) begin
			check("tally at switch-on", 10'(t_q >= v_q), 10'h001);
		end
		started <= RSTN && SUPPLY_ON && (started || GATE_DRIVE);
		g_q <= GATE_DRIVE;
		t_q <= CROSSING_TALLY;
		v_q <= VALLEY_INDEX;
	end

	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial begin
		{RSTN, SUPPLY_ON, FB_ABOVE_UP, FB_ABOVE_DOWN, FB_ABOVE_RAPID, LINE_HIGH, pulse_en} = 7'h00;
		{failures, num_checks} = '0;
		wait_cyc(20);
		idle_vals();
		check("valley", 10'(VALLEY_INDEX), 10'h001);
		check("limit", CS_LIMIT_MV, 10'h140);
		@(posedge CLK_SYS);
		RSTN <= 1'b1;
		SUPPLY_ON <= 1'b1;
		pulse_en <= 1'b1;
		wait_cyc(30);
		check("charge", 10'(STARTUP_CHARGE_EN), 10'h000);
		check("limit", CS_LIMIT_MV, 10'h140);
		wait_cyc(50);
		check("limit", CS_LIMIT_MV, 10'h223);
		wait_cyc(50);
		check("limit", CS_LIMIT_MV, 10'h305);
		wait_cyc(9);
		$display("soft-start test done");
		foreach (rows[i]) begin
			@(posedge CLK_SYS);
			FB_ABOVE_UP <= rows[i][4:3] >= 2'h1;
			FB_ABOVE_DOWN <= rows[i][4:3] >= 2'h2;
			FB_ABOVE_RAPID <= rows[i][4:3] == 2'h3;
			wait_cyc(200);
			check("valley", 10'(VALLEY_INDEX), 10'(rows[i][2:0]));
		end
		check("limit", CS_LIMIT_MV, 10'h3E8);
		$display("valley table test done");
		@(posedge CLK_SYS);
		pulse_en <= 1'b0;
		wait_cyc(1);
		wait_gate(1'b1, n);
		wait_gate(1'b0, n);
		wait_gate(1'b1, n);
		check("max off", 10'(n), 10'h064);
		check("tally", 10'(CROSSING_TALLY), 10'h000);
		$display("max off test done");
		@(posedge CLK_SYS);
		LINE_HIGH <= 1'b1;
		pulse_en <= 1'b1;
		wait_cyc(8);
		check("thresh sel", 10'(FB_THRESH_SEL), 10'h001);
		@(posedge CLK_SYS);
		LINE_HIGH <= 1'b0;
		wait_cyc(8);
		check("thresh sel", 10'(FB_THRESH_SEL), 10'h000);
		wait_cyc(300);
		@(posedge CLK_SYS);
		SUPPLY_ON <= 1'b0;
		wait_cyc(8);
		idle_vals();
		@(posedge CLK_SYS);
		SUPPLY_ON <= 1'b1;
		wait_cyc(10);
		check("valley", 10'(VALLEY_INDEX), 10'h001);
		check("limit", CS_LIMIT_MV, 10'h140);
		$display("supply cycle test done");
		wait_cyc(300);
		@(posedge CLK_SYS);
		RSTN <= 1'b0;
		wait_cyc(2);
		idle_vals();
		check("valley", 10'(VALLEY_INDEX), 10'h001);
		$display("mid-run reset test done");
		stop_test();
	end
endmodule
